// ---- inc/cdt_pkg.sv ----
// constants shared by the timing override bank and its entries
package cdt_pkg;

  // bus and field widths
  localparam int CDT_NUM_REGS = 6;
  localparam int CDT_ADDR_W   = 8;
  localparam int CDT_DATA_W   = 8;
  localparam int CDT_VAL_W    = 7;

  // field positions inside each timing register
  localparam int CDT_FLAG_BIT = 7;
  localparam int CDT_VAL_MSB  = 6;
  localparam int CDT_VAL_LSB  = 0;

  // register offsets on the indirect page
  localparam logic [7:0] CDT_OFF_CLOCK_PREPARE = 8'h40;
  localparam logic [7:0] CDT_OFF_CLOCK_ZERO    = 8'h41;
  localparam logic [7:0] CDT_OFF_CLOCK_TRAIL   = 8'h42;
  localparam logic [7:0] CDT_OFF_CLOCK_POST    = 8'h43;
  localparam logic [7:0] CDT_OFF_DATA_PREPARE  = 8'h44;
  localparam logic [7:0] CDT_OFF_DATA_ZERO     = 8'h45;

  // entry index of each register, offset table in index order
  localparam int CDT_IDX_CLOCK_PREPARE = 0;
  localparam int CDT_IDX_CLOCK_ZERO    = 1;
  localparam int CDT_IDX_CLOCK_TRAIL   = 2;
  localparam int CDT_IDX_CLOCK_POST    = 3;
  localparam int CDT_IDX_DATA_PREPARE  = 4;
  localparam int CDT_IDX_DATA_ZERO     = 5;
  localparam logic [CDT_NUM_REGS-1:0][CDT_ADDR_W-1:0] CDT_OFFSETS = {
    CDT_OFF_DATA_ZERO, CDT_OFF_DATA_PREPARE, CDT_OFF_CLOCK_POST,
    CDT_OFF_CLOCK_TRAIL, CDT_OFF_CLOCK_ZERO, CDT_OFF_CLOCK_PREPARE};

  // reset values
  localparam logic                  CDT_FLAG_RST  = 1'h0;
  localparam logic [CDT_VAL_W-1:0]  CDT_VAL_RST   = 7'h00;
  localparam logic [CDT_DATA_W-1:0] CDT_RDATA_IDLE = 8'h00;

endpackage : cdt_pkg

// ---- inc/cdt_entry_if.sv ----
// carrier between the bank decoder and one timing entry
`timescale 1ns/100ps
interface cdt_entry_if;
  logic                          wr;
  logic [cdt_pkg::CDT_DATA_W-1:0] wdata;
  logic [cdt_pkg::CDT_VAL_W-1:0]  auto_value;
  logic                          flag;
  logic [cdt_pkg::CDT_VAL_W-1:0]  applied;
  logic [cdt_pkg::CDT_DATA_W-1:0] readback;

  // bank side drives the write and the automatic value
  modport bank (
    output wr,
    output wdata,
    output auto_value,
    input  flag,
    input  applied,
    input  readback
  );

  // entry side holds the override state
  modport entry (
    input  wr,
    input  wdata,
    input  auto_value,
    output flag,
    output applied,
    output readback
  );
endinterface : cdt_entry_if

// ---- rtl/cdt_timing_entry.sv ----
// one timing register: override flag, override value, selection
`timescale 1ns/100ps
module cdt_timing_entry (
  input  wire logic  sys_clk_in,
  input  wire logic  reset_n_in,
  cdt_entry_if.entry port
);

  logic                          flag;
  logic [cdt_pkg::CDT_VAL_W-1:0] value;
  logic                          next_flag;
  logic [cdt_pkg::CDT_VAL_W-1:0] next_value;

  // a write always updates the flag; the value field only takes data
  // when the same write leaves the override on, so writes that leave
  // the parameter automatic never disturb the stored value
  always_comb begin
    next_flag  = flag;
    next_value = value;
    if (port.wr) begin
      next_flag = port.wdata[cdt_pkg::CDT_FLAG_BIT];
      if (port.wdata[cdt_pkg::CDT_FLAG_BIT]) begin
        next_value = port.wdata[cdt_pkg::CDT_VAL_MSB:
                                cdt_pkg::CDT_VAL_LSB];
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      flag  <= cdt_pkg::CDT_FLAG_RST;
      value <= cdt_pkg::CDT_VAL_RST;
    end else begin
      flag  <= next_flag;
      value <= next_value;
    end
  end

  // the parameter in use and what software sees on a read
  assign port.flag     = flag;
  assign port.applied  = flag ? value : port.auto_value;
  assign port.readback = {flag, port.applied};

endmodule : cdt_timing_entry

// ---- rtl/cdt_timing_bank.sv ----
// d-phy timing override register bank for csi-2 output port 0
//
// What this block does
// - clock prepare flag set: use its value
// - clock zero flag set: use its value
// - clock trail flag set: use its value
// - clock post flag set: use its value
// - data prepare flag set: use its value
// - data zero flag set: use its value
// - flag clear: parameter follows automatic choice
// - flag clear: field reads automatic value, read-only
// - flag set: field writable and reads back
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
module cdt_timing_bank (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic [cdt_pkg::CDT_ADDR_W-1:0] reg_addr_in,
  input  wire logic [cdt_pkg::CDT_DATA_W-1:0] reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [cdt_pkg::CDT_DATA_W-1:0] reg_rdata_out,
  input  wire logic [cdt_pkg::CDT_NUM_REGS-1:0]
                    [cdt_pkg::CDT_VAL_W-1:0]  auto_value_in,
  output logic      [cdt_pkg::CDT_NUM_REGS-1:0]
                    [cdt_pkg::CDT_VAL_W-1:0]  applied_value_out,
  output logic      [cdt_pkg::CDT_NUM_REGS-1:0] override_active_out
);

  localparam int NR = cdt_pkg::CDT_NUM_REGS;
  localparam int VW = cdt_pkg::CDT_VAL_W;
  localparam int DW = cdt_pkg::CDT_DATA_W;

  logic [NR-1:0]         hit;
  logic [NR-1:0]         wr_hit;
  logic [NR-1:0]         flag_vec;
  logic [NR-1:0][VW-1:0] appl_vec;
  logic [NR-1:0][DW-1:0] rb_vec;
  logic [DW-1:0]         rdata;
  logic [DW-1:0]         next_rdata;
  logic [NR-1:0][VW-1:0] applied;
  logic [NR-1:0][VW-1:0] next_applied;
  logic [NR-1:0]         ovr;
  logic [NR-1:0]         next_ovr;

  cdt_entry_if ent [NR] ();

  // one entry per timing register; the address decode is a plain
  // compare against the offset table, so any other address is ignored
  for (genvar i = 0; i < NR; i++) begin : g_ent
    assign hit[i]              = reg_addr_in == cdt_pkg::CDT_OFFSETS[i];
    assign wr_hit[i]           = reg_wr_in & hit[i];
    assign ent[i].wr           = wr_hit[i];
    assign ent[i].wdata        = reg_wdata_in;
    assign ent[i].auto_value   = auto_value_in[i];
    assign flag_vec[i]         = ent[i].flag;
    assign appl_vec[i]         = ent[i].applied;
    assign rb_vec[i]           = ent[i].readback;

    cdt_timing_entry u_entry (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .port       (ent[i].entry)
    );
  end

  // read mux: data stands only in the cycle after the strobe, and an
  // unmapped address reads as zero rather than holding stale data
  always_comb begin
    next_rdata = cdt_pkg::CDT_RDATA_IDLE;
    for (int i = 0; i < NR; i++) begin
      if (reg_rd_in && hit[i]) begin
        next_rdata = rb_vec[i];
      end
    end
  end

  // parameters handed to the d-phy sequencer; registered so the
  // sequencer sees clean flop outputs, at the cost of one cycle
  always_comb begin
    next_applied = appl_vec;
    next_ovr     = flag_vec;
  end

  // output registers
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rdata   <= cdt_pkg::CDT_RDATA_IDLE;
      applied <= '0;
      ovr     <= '0;
    end else begin
      rdata   <= next_rdata;
      applied <= next_applied;
      ovr     <= next_ovr;
    end
  end

  assign reg_rdata_out       = rdata;
  assign applied_value_out   = applied;
  assign override_active_out = ovr;

  // checks on the design's own behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  localparam int IP = cdt_pkg::CDT_IDX_CLOCK_PREPARE;
  localparam int IZ = cdt_pkg::CDT_IDX_CLOCK_ZERO;
  localparam int IT = cdt_pkg::CDT_IDX_CLOCK_TRAIL;
  localparam int IO = cdt_pkg::CDT_IDX_CLOCK_POST;
  localparam int DP = cdt_pkg::CDT_IDX_DATA_PREPARE;
  localparam int DZ = cdt_pkg::CDT_IDX_DATA_ZERO;
  localparam int FB = cdt_pkg::CDT_FLAG_BIT;

  // override write to clock prepare reaches the output two cycles on
  a_clk_prep_ovr: assert property (
    (wr_hit[IP] && reg_wdata_in[FB]) ##1 !wr_hit[IP]
    |=> applied_value_out[IP] == $past(reg_wdata_in[VW-1:0], 2)
        && override_active_out[IP])
    else $error("clock prepare override not applied");

  // clock zero takes the written value and keeps it while untouched
  a_clk_zero_ovr: assert property (
    (wr_hit[IZ] && reg_wdata_in[FB]) ##1 !wr_hit[IZ] [*2]
    |-> applied_value_out[IZ] == $past(reg_wdata_in[VW-1:0], 2)
        ##1 applied_value_out[IZ] == $past(applied_value_out[IZ]))
    else $error("clock zero override lost");

  // clock trail override ignores the automatic value entirely
  a_clk_trail_ovr: assert property (
    (flag_vec[IT] && !wr_hit[IT]) ##1 $changed(auto_value_in[IT])
    |=> $stable(applied_value_out[IT]))
    else $error("clock trail follows automatic while overridden");

  // clock post output tracks the override field
  a_clk_post_ovr: assert property (
    (wr_hit[IO] && reg_wdata_in[FB]) ##1 !wr_hit[IO]
    |=> applied_value_out[IO] == $past(reg_wdata_in[VW-1:0], 2))
    else $error("clock post override not applied");

  // data prepare override shows as an active flag and value
  a_dat_prep_ovr: assert property (
    (wr_hit[DP] && reg_wdata_in[FB]) ##1 !wr_hit[DP]
    |=> override_active_out[DP]
        && applied_value_out[DP] == $past(reg_wdata_in[VW-1:0], 2))
    else $error("data prepare override not applied");

  // data zero override beats a different automatic value
  a_dat_zero_ovr: assert property (
    (wr_hit[DZ] && reg_wdata_in[FB]
     && reg_wdata_in[VW-1:0] != auto_value_in[DZ]) ##1 !wr_hit[DZ]
    |=> applied_value_out[DZ] == $past(reg_wdata_in[VW-1:0], 2))
    else $error("data zero override not applied");

  for (genvar i = 0; i < NR; i++) begin : g_chk
    // with no override the output follows the automatic choice
    a_auto_follow: assert property (
      reset_n_in && !flag_vec[i]
      |=> applied_value_out[i] == $past(auto_value_in[i])
          && !override_active_out[i])
      else $error("automatic value not applied");

    // a read with the flag clear returns the automatic value
    a_auto_readback: assert property (
      (reg_rd_in && hit[i] && !flag_vec[i])
      |=> reg_rdata_out == {1'b0, $past(auto_value_in[i])})
      else $error("read did not show automatic value");

    // an override write reads back on the following read
    a_ovr_readback: assert property (
      (wr_hit[i] && reg_wdata_in[FB]) ##1 (reg_rd_in && hit[i])
      |=> reg_rdata_out == {1'b1, $past(reg_wdata_in[VW-1:0], 2)})
      else $error("override value did not read back");

    // clearing the flag hands the parameter back to the device
    a_clear_resume: assert property (
      (wr_hit[i] && !reg_wdata_in[FB])
      |=> !flag_vec[i]
          ##1 applied_value_out[i] == $past(auto_value_in[i])
              && !override_active_out[i])
      else $error("automatic value not resumed");

    // an override write sets the flag and loads the value at once
    a_ovr_set: assert property (
      (wr_hit[i] && reg_wdata_in[FB])
      |=> flag_vec[i]
          && appl_vec[i] == $past(reg_wdata_in[VW-1:0]))
      else $error("override write not taken");

    // an override stays put until software writes the register again
    a_ovr_hold: assert property (
      (flag_vec[i] && !wr_hit[i])
      |=> flag_vec[i] && appl_vec[i] == $past(appl_vec[i]))
      else $error("override value drifted");

    // automatic mode is left only by a write with the flag bit set
    a_auto_keep: assert property (
      (!flag_vec[i] && !(wr_hit[i] && reg_wdata_in[FB]))
      |=> !flag_vec[i])
      else $error("override entered without a write");

    // a clearing write shows the automatic value on the next cycle
    a_clear_shows: assert property (
      (wr_hit[i] && !reg_wdata_in[FB])
      |=> rb_vec[i] == {1'b0, auto_value_in[i]})
      else $error("cleared entry does not show automatic value");

    // a read with the flag set returns the flag and the stored value
    a_read_ovr: assert property (
      (reg_rd_in && hit[i] && flag_vec[i])
      |=> reg_rdata_out[FB]
          && reg_rdata_out[VW-1:0] == $past(appl_vec[i]))
      else $error("override read lost flag or value");

    // writes to other addresses and plain reads leave the entry alone
    a_wr_other: assert property (
      ((reg_wr_in && !hit[i]) || (reg_rd_in && !reg_wr_in))
      |=> flag_vec[i] == $past(flag_vec[i])
          && (!flag_vec[i] || appl_vec[i] == $past(appl_vec[i])))
      else $error("entry changed without a write to it");

    // reset leaves every entry automatic and its outputs at zero
    a_reset_state: assert property (
      disable iff (1'b0)
      !reset_n_in
      |=> !flag_vec[i] && !override_active_out[i]
          && applied_value_out[i] == '0)
      else $error("entry not cleared by reset");
  end

  // read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == cdt_pkg::CDT_RDATA_IDLE)
    else $error("read data outside its cycle");

  // an unmapped read returns the idle value, never stale data
  a_rd_unmapped: assert property (
    (reg_rd_in && !(|hit))
    |=> reg_rdata_out == cdt_pkg::CDT_RDATA_IDLE)
    else $error("unmapped read returned data");

  // reset drives the read data to its idle value
  a_reset_rdata: assert property (
    disable iff (1'b0)
    !reset_n_in |=> reg_rdata_out == cdt_pkg::CDT_RDATA_IDLE)
    else $error("read data not cleared by reset");

endmodule : cdt_timing_bank

// ---- verif/cdt_auto_model.sv ----
// partner model: the device's automatic timing engine feeding the bank
`timescale 1ns/100ps
module cdt_auto_model (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        step_in,
  output logic [cdt_pkg::CDT_NUM_REGS-1:0]
               [cdt_pkg::CDT_VAL_W-1:0] auto_value_out
);
  logic [6:0] base;

  // base moves only on request, so the bench can predict every value
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      base <= 7'h05;
    end else if (step_in) begin
      base <= base + 7'h13;
    end
  end

  // distinct offset per parameter so crossed lanes show up
  always_comb begin
    for (int i = 0; i < cdt_pkg::CDT_NUM_REGS; i++) begin
      auto_value_out[i] = base + 7'(i) * 7'h0b;
    end
  end
endmodule : cdt_auto_model

// ---- verif/cdt_timing_bank_tb.sv ----
// self-checking bench for the timing override bank
`timescale 1ns/100ps
module cdt_timing_bank_tb;
  localparam int N = cdt_pkg::CDT_NUM_REGS;
  logic              sys_clk_in;
  logic              reset_n_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic              step;
  logic [7:0]        reg_addr_in;
  logic [7:0]        reg_wdata_in;
  logic [7:0]        reg_rdata_out;
  logic [N-1:0][6:0] auto_value;
  logic [N-1:0][6:0] applied;
  logic [N-1:0]      ovr;
  logic [6:0]        base;
  int                bad_count;
  int                n_tests;

  cdt_timing_bank cdt_timing_bank_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .auto_value_in(auto_value),
    .applied_value_out(applied), .override_active_out(ovr));

  cdt_auto_model cdt_auto_model_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .step_in(step), .auto_value_out(auto_value));

  // free-running 200 MHz clock
  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task conclude;
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // one-cycle write strobe, then an idle cycle before the next request
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'h0;
    @(posedge sys_clk_in);
  endtask : wr

  // write strobe followed at once by a read strobe of the same register
  task wr_rd(input logic [7:0] a, input logic [7:0] d,
             input logic [7:0] e);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'h0;
    rd(a, e);
  endtask : wr_rd

  // read data stands only in the cycle after the strobe, then idles at 0
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'h1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'h0;
    @(negedge sys_clk_in);
    chk("rdata", reg_rdata_out, e);
    @(negedge sys_clk_in);
    chk("rdata_idle", reg_rdata_out, 8'h00);
    @(posedge sys_clk_in);
  endtask : rd

  // parameter output and override copy of one entry
  task par(input int i, input logic o, input logic [6:0] v);
    @(negedge sys_clk_in);
    chk("applied", {1'h0, applied[i]}, {1'h0, v});
    chk("override", {7'h00, ovr[i]}, {7'h00, o});
    @(posedge sys_clk_in);
  endtask : par

  // move the automatic values; two edges let the registered outputs follow
  task step_auto;
    step <= 1'h1;
    @(posedge sys_clk_in);
    step <= 1'h0;
    base = base + 7'h13;
    @(posedge sys_clk_in);
  endtask : step_auto

  function automatic logic [6:0] aexp(input int i);
    return base + 7'(i) * 7'h0b;
  endfunction : aexp

  function automatic logic [6:0] ov(input int i);
    return 7'h7f - 7'(i) * 7'h19;
  endfunction : ov

  // hang guard; every wait below is a fixed count
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    bad_count++;
    conclude();
  end

  initial begin
    reset_n_in = 1'h0;
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
    step = 1'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    bad_count = 0;
    n_tests = 0;
    base = 7'h05;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    // flags clear: field and outputs track the automatic value
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < N; i++) begin
        rd(cdt_pkg::CDT_OFFSETS[i], {1'h0, aexp(i)});
        par(i, 1'h0, aexp(i));
      end
      step_auto();
    end
    // a value written with the flag clear must not stick
    for (int i = 0; i < N; i++) begin
      wr(cdt_pkg::CDT_OFFSETS[i], 8'h2a);
      rd(cdt_pkg::CDT_OFFSETS[i], {1'h0, aexp(i)});
      par(i, 1'h0, aexp(i));
    end
    // override every entry with its own value, then move the auto values
    for (int i = 0; i < N; i++) begin
      wr_rd(cdt_pkg::CDT_OFFSETS[i], {1'h1, ov(i)}, {1'h1, ov(i)});
    end
    step_auto();
    for (int i = 0; i < N; i++) begin
      par(i, 1'h1, ov(i));
    end
    // neighbours of the bank are not mapped
    wr(8'h46, 8'hff);
    rd(8'h46, 8'h00);
    rd(8'h3f, 8'h00);
    // clearing the flag hands the parameter back to the device
    for (int i = 0; i < N; i++) begin
      wr(cdt_pkg::CDT_OFFSETS[i], 8'h55);
      rd(cdt_pkg::CDT_OFFSETS[i], {1'h0, aexp(i)});
      par(i, 1'h0, aexp(i));
    end
    conclude();
  end
endmodule : cdt_timing_bank_tb
